// ===== inc/slpr_pkg.sv
// package: register map, field layout and reset values of the link parameter bank
package slpr_pkg;
  localparam logic [7:0] ADDR_BANK_ID = 8'h65;
  localparam logic [7:0] ADDR_LANE_ID = 8'h67;
  localparam logic [7:0] ADDR_SCR_LANES = 8'h6E;
  localparam logic [7:0] ADDR_OCTETS = 8'h6F;
  localparam logic [7:0] ADDR_FRAMES = 8'h70;
  localparam logic [7:0] ADDR_CONVS = 8'h71;
  localparam logic [7:0] ADDR_CS_RES = 8'h72;
  localparam logic [7:0] ADDR_SUB_CONT = 8'h73;
  localparam logic [7:0] ADDR_SAMPLES = 8'h74;
  localparam logic [7:0] ADDR_HD_CF = 8'h75;
  localparam logic [7:0] ADDR_LINK_RESERVED_ONE = 8'h76;

  localparam logic [7:0] RST_BANK_ID = 8'h00;
  localparam logic [7:0] RST_LANE_ID = 8'h00;
  localparam logic [7:0] RST_SCR_LANES = 8'h00;
  localparam logic [7:0] RST_OCTETS = 8'h01;
  localparam logic [7:0] RST_FRAMES = 8'h1F;
  localparam logic [7:0] RST_CONVS = 8'h00;
  localparam logic [7:0] RST_CS_RES = 8'h0D;
  localparam logic [7:0] RST_SUB_CONT = 8'h2F;
  localparam logic [7:0] RST_SAMPLES = 8'h20;
  localparam logic [7:0] RST_HD_CF = 8'h00;
  localparam logic [7:0] RST_LINK_RESERVED_ONE = 8'h00;

  // fixed converter facts
  localparam logic [4:0] RES_CODE_11BIT = 5'h0A;
  localparam logic [4:0] CONT_CODE_16BIT = 5'h0F;
  // writable masks; bit 5 of the samples register is fixed at one
  localparam logic [7:0] MASK_BANK_ID = 8'h0F;
  localparam logic [7:0] MASK_LANE_ID = 8'h1F;
  localparam logic [7:0] MASK_SCR_LANES = 8'h9F;
  localparam logic [7:0] MASK_FRAMES = 8'h1F;
  localparam logic [7:0] MASK_CONVS = 8'hFF;
  localparam logic [7:0] MASK_CS_RES = 8'hC0;
  localparam logic [7:0] MASK_SUB_CONT = 8'h60;
  localparam logic [7:0] MASK_SAMPLES = 8'h1F;
  localparam logic [7:0] FIXED_SAMPLES = 8'h20;

  typedef struct packed {
    logic       scrEnable;
    logic [4:0] laneCount;
    logic [4:0] framesPerMf;
    logic [7:0] converters;
    logic [1:0] controlBits;
    logic [4:0] resolution;
    logic [1:0] subclass;
    logic [4:0] containerBits;
    logic [4:0] samplesPerFrame;
  } slpr_cfg_t;
endpackage

// ===== verilog/slpr_param_regs.sv
// link parameter register bank behind the serial control port
// Overview of operation
// - a stored lane count of zero means one lane per link.
// - the resolution field always holds 0xA, meaning an 11-bit converter.
// - the container width field holds width minus one, 0xF meaning 16 bits.
// - control bits per sample decode 00 to none, 01 to one, 10 to two.
`timescale 1ns/1ps
`default_nettype none
module slpr_param_regs (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData_r,
  output logic rdValid_r,
  output slpr_pkg::slpr_cfg_t cfg_r,
  output logic [5:0] lanesActual_r,
  output logic [1:0] ctrlBitsActual_r
);
  import slpr_pkg::*;

  logic [7:0] bankId_r, laneId_r, scrLanes_r, frames_r, convs_r;
  logic [7:0] csRes_r, subCont_r, samples_r;
  logic [7:0] rdMux;

  // one process per register; read-only bits are never loaded from the port
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bankId_r <= RST_BANK_ID;
    end else if (wrEn && addr == ADDR_BANK_ID) begin
      bankId_r <= wrData & MASK_BANK_ID;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      laneId_r <= RST_LANE_ID;
    end else if (wrEn && addr == ADDR_LANE_ID) begin
      laneId_r <= wrData & MASK_LANE_ID;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scrLanes_r <= RST_SCR_LANES;
    end else if (wrEn && addr == ADDR_SCR_LANES) begin
      scrLanes_r <= wrData & MASK_SCR_LANES;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frames_r <= RST_FRAMES;
    end else if (wrEn && addr == ADDR_FRAMES) begin
      frames_r <= wrData & MASK_FRAMES;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      convs_r <= RST_CONVS;
    end else if (wrEn && addr == ADDR_CONVS) begin
      convs_r <= wrData & MASK_CONVS;
    end
  end

  // the resolution field is the fixed 11-bit code even straight out of
  // reset; the reset byte only seeds the writable control-bit field
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      csRes_r <= (RST_CS_RES & MASK_CS_RES)
                 | {3'h0, RES_CODE_11BIT};
    end else if (wrEn && addr == ADDR_CS_RES) begin
      csRes_r <= (wrData & MASK_CS_RES)
                 | {3'h0, RES_CODE_11BIT};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      subCont_r <= RST_SUB_CONT;
    end else if (wrEn && addr == ADDR_SUB_CONT) begin
      subCont_r <= (wrData & MASK_SUB_CONT)
                   | {3'h0, CONT_CODE_16BIT};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      samples_r <= RST_SAMPLES;
    end else if (wrEn && addr == ADDR_SAMPLES) begin
      samples_r <= (wrData & MASK_SAMPLES) | FIXED_SAMPLES;
    end
  end

  // octets, header/control words and reserved have no storage

  always_comb begin
    case (addr)
      ADDR_BANK_ID: rdMux = bankId_r;
      ADDR_LANE_ID: rdMux = laneId_r;
      ADDR_SCR_LANES: rdMux = scrLanes_r;
      ADDR_OCTETS: rdMux = RST_OCTETS;
      ADDR_FRAMES: rdMux = frames_r;
      ADDR_CONVS: rdMux = convs_r;
      ADDR_CS_RES: rdMux = csRes_r;
      ADDR_SUB_CONT: rdMux = subCont_r;
      ADDR_SAMPLES: rdMux = samples_r;
      ADDR_HD_CF: rdMux = RST_HD_CF;
      ADDR_LINK_RESERVED_ONE: rdMux = RST_LINK_RESERVED_ONE;
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdData_r <= 8'h00;
      rdValid_r <= 1'b0;
    end else begin
      rdData_r <= rdEn ? rdMux : rdData_r;
      rdValid_r <= rdEn;
    end
  end

  // decoded view for the link logic, one cycle behind the registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_r <= '0;
      lanesActual_r <= 6'h00;
      ctrlBitsActual_r <= 2'h0;
    end else begin
      cfg_r.scrEnable <= scrLanes_r[7];
      cfg_r.laneCount <= scrLanes_r[4:0];
      cfg_r.framesPerMf <= frames_r[4:0];
      cfg_r.converters <= convs_r;
      cfg_r.controlBits <= csRes_r[7:6];
      cfg_r.resolution <= csRes_r[4:0];
      cfg_r.subclass <= subCont_r[6:5];
      cfg_r.containerBits <= subCont_r[4:0];
      cfg_r.samplesPerFrame <= samples_r[4:0];
      lanesActual_r <= {1'b0, scrLanes_r[4:0]} + 6'h01;
      case (csRes_r[7:6])
        2'b00: ctrlBitsActual_r <= 2'h0;
        2'b01: ctrlBitsActual_r <= 2'h1;
        2'b10: ctrlBitsActual_r <= 2'h2;
        default: ctrlBitsActual_r <= 2'h0;
      endcase
    end
  end

  // a read is a request edge followed by exactly one answer edge
  sequence s_rd_req;
    rdEn;
  endsequence
  sequence s_rd_answer;
    rdValid_r;
  endsequence
  sequence s_wr_frames;
    wrEn && addr == ADDR_FRAMES;
  endsequence
  sequence s_wr_samples;
    wrEn && addr == ADDR_SAMPLES;
  endsequence

  a_res_fixed: assert property (
    @(posedge clk) disable iff (!rstn)
    csRes_r[4:0] == RES_CODE_11BIT)
    else $error("resolution field not 11-bit code");
  a_cont_fixed: assert property (
    @(posedge clk) disable iff (!rstn)
    subCont_r[4:0] == CONT_CODE_16BIT)
    else $error("container width field not 16-bit code");
  a_lane_zero: assert property (
    @(posedge clk) disable iff (!rstn)
    scrLanes_r[4:0] == 5'h00 |=> lanesActual_r == 6'h01)
    else $error("lane count zero not one lane");
  a_lane_max: assert property (
    @(posedge clk) disable iff (!rstn)
    scrLanes_r[4:0] == 5'h1F |=> lanesActual_r == 6'h20)
    else $error("largest lane count not 32 lanes");
  a_ctrl_decode: assert property (
    @(posedge clk) disable iff (!rstn)
    csRes_r[7:6] == 2'b10 |=> ctrlBitsActual_r == 2'h2)
    else $error("control bits decode wrong");
  a_ctrl_one: assert property (
    @(posedge clk) disable iff (!rstn)
    csRes_r[7:6] == 2'b01 |=> ctrlBitsActual_r == 2'h1)
    else $error("one control bit decode wrong");
  a_ctrl_none: assert property (
    @(posedge clk) disable iff (!rstn)
    csRes_r[7:6] == 2'b00 |=> ctrlBitsActual_r == 2'h0)
    else $error("no control bits decode wrong");
  a_ro_octets: assert property (
    @(posedge clk) disable iff (!rstn)
    rdEn && addr == ADDR_OCTETS |=> rdData_r == RST_OCTETS)
    else $error("octets per frame changed");
  a_ro_header: assert property (
    @(posedge clk) disable iff (!rstn)
    rdEn && addr == ADDR_HD_CF |=> rdData_r == RST_HD_CF)
    else $error("header and control words changed");
  a_samples_fixed: assert property (
    @(posedge clk) disable iff (!rstn)
    samples_r[7:5] == 3'h1)
    else $error("samples register fixed bits changed");
  a_spare_bits: assert property (
    @(posedge clk) disable iff (!rstn)
    subCont_r[7] == 1'b0 && csRes_r[5] == 1'b0)
    else $error("unused register bit became set");
  a_frames_write: assert property (
    @(posedge clk) disable iff (!rstn)
    s_wr_frames |=> frames_r == ($past(wrData) & MASK_FRAMES))
    else $error("frames per multiframe write lost");
  a_samples_write: assert property (
    @(posedge clk) disable iff (!rstn)
    s_wr_samples |=> samples_r[4:0] == $past(wrData[4:0]))
    else $error("samples per frame write lost");
  a_cfg_res: assert property (
    @(posedge clk) disable iff (!rstn)
    1'b1 |=> cfg_r.resolution == RES_CODE_11BIT)
    else $error("decoded resolution not 11-bit code");
  a_cfg_cont: assert property (
    @(posedge clk) disable iff (!rstn)
    1'b1 |=> cfg_r.containerBits == CONT_CODE_16BIT)
    else $error("decoded container width not 16-bit code");
  a_rd_answer: assert property (
    @(posedge clk) disable iff (!rstn)
    s_rd_req |=> s_rd_answer)
    else $error("read answer missing");
  a_rd_quiet: assert property (
    @(posedge clk) disable iff (!rstn)
    !rdEn |=> !rdValid_r && $stable(rdData_r))
    else $error("read answer without request");
endmodule // slpr_param_regs
`default_nettype wire

// ===== testbench/slpr_host.sv
// host model driving the register access strobes
`timescale 1ns/1ps
`default_nettype none
module slpr_host (
  input wire logic clk,
  input wire logic [7:0] rdData_r,
  output logic wrEn,
  output logic rdEn,
  output logic [7:0] addr,
  output logic [7:0] wrData
);
  initial begin
    wrEn = 1'b0;
    rdEn = 1'b0;
    addr = 8'h00;
    wrData = 8'h00;
  end
  // released data is inverted so a stale byte cannot pass for a write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wrEn <= 1'b1;
    addr <= a;
    wrData <= d;
    @(posedge clk);
    wrEn <= 1'b0;
    wrData <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rdEn <= 1'b1;
    addr <= a;
    @(posedge clk);
    rdEn <= 1'b0;
    @(negedge clk);
    d = rdData_r;
  endtask
endmodule // slpr_host
`default_nettype wire

// ===== testbench/serial_link_param_regs_tb.sv
// self-checking bench of the link parameter register bank
`timescale 1ns/1ps
`default_nettype none
module serial_link_param_regs_tb;
  import slpr_pkg::*;
  logic clk;
  logic rstn;
  logic wrEn;
  logic rdEn;
  logic [7:0] addr;
  logic [7:0] wrData;
  logic [7:0] rdData_r;
  logic rdValid_r;
  logic [7:0] v;
  slpr_cfg_t cfg_r;
  logic [5:0] lanesActual_r;
  logic [1:0] ctrlBitsActual_r;
  int bad_count = 0;
  int comparisons = 0;
  // address in the high byte, reset value in the low byte
  logic [15:0] rv [11] = '{16'h6500, 16'h6700, 16'h6E00, 16'h6F01,
    16'h701F, 16'h7100, 16'h720A, 16'h732F, 16'h7420, 16'h7500,
    16'h7600};
  slpr_param_regs u_dut (.clk(clk), .rstn(rstn), .wrEn(wrEn),
    .rdEn(rdEn), .addr(addr), .wrData(wrData), .rdData_r(rdData_r),
    .rdValid_r(rdValid_r), .cfg_r(cfg_r), .lanesActual_r(lanesActual_r),
    .ctrlBitsActual_r(ctrlBitsActual_r));
  slpr_host u_host (.clk(clk), .rdData_r(rdData_r), .wrEn(wrEn),
    .rdEn(rdEn), .addr(addr), .wrData(wrData));
  task automatic chk(input string n, input logic [7:0] s,
                     input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #20000;
    bad_count++;
    end_of_test;
  end
  initial begin
    rstn = 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    foreach (rv[i]) begin
      u_host.rd(rv[i][15:8], v);
      chk("reset", v, rv[i][7:0]);
      chk("valid", 8'(rdValid_r), 8'h01);
      if (rv[i][15:8] inside {8'h6F, 8'h75, 8'h76}) begin
        u_host.wr(rv[i][15:8], 8'hFF);
        u_host.rd(rv[i][15:8], v);
        chk("readonly", v, rv[i][7:0]);
      end
    end
    for (int i = 0; i < 3; i++) begin
      u_host.wr(8'h6E, 8'(i));
      u_host.wr(8'h72, 8'(i << 6));
      repeat (3) @(negedge clk);
      chk("lanes", 8'(lanesActual_r), 8'(i + 1));
      chk("ctrl", 8'(ctrlBitsActual_r), 8'(i));
    end
    u_host.wr(8'h72, 8'hFF);
    u_host.wr(8'h73, 8'hFF);
    u_host.rd(8'h73, v);
    chk("subcont", v, 8'h6F);
    chk("res", 8'(cfg_r.resolution), 8'h0A);
    chk("cont", 8'(cfg_r.containerBits), 8'h0F);
    chk("ctrl3", 8'(ctrlBitsActual_r), 8'h00);
    chk("csfield", 8'(cfg_r.controlBits), 8'h03);
    chk("subclass", 8'(cfg_r.subclass), 8'h03);
    u_host.wr(ADDR_BANK_ID, 8'hFF);
    u_host.rd(ADDR_BANK_ID, v);
    chk("bankid", v, MASK_BANK_ID);
    u_host.wr(ADDR_LANE_ID, 8'hFF);
    u_host.rd(ADDR_LANE_ID, v);
    chk("laneid", v, MASK_LANE_ID);
    u_host.wr(ADDR_SCR_LANES, 8'hFF);
    u_host.rd(ADDR_SCR_LANES, v);
    chk("scrlanes", v, 8'h9F);
    chk("scren", 8'(cfg_r.scrEnable), 8'h01);
    chk("lanesmax", 8'(lanesActual_r), 8'h20);
    u_host.wr(ADDR_FRAMES, 8'hE3);
    u_host.rd(ADDR_FRAMES, v);
    chk("frames", v, 8'h03);
    chk("framescfg", 8'(cfg_r.framesPerMf), 8'h03);
    u_host.wr(ADDR_CONVS, 8'h5A);
    u_host.rd(ADDR_CONVS, v);
    chk("convs", v, 8'h5A);
    chk("convscfg", cfg_r.converters, 8'h5A);
    u_host.wr(ADDR_SAMPLES, 8'hC4);
    u_host.rd(ADDR_SAMPLES, v);
    chk("samples", v, 8'h24);
    chk("samplescfg", 8'(cfg_r.samplesPerFrame), 8'h04);
    u_host.wr(ADDR_SUB_CONT, 8'h00);
    u_host.rd(ADDR_SUB_CONT, v);
    chk("subcont0", v, 8'h0F);
    u_host.rd(8'h66, v);
    chk("unmapped", v, 8'h00);
    // second reset in mid-run, host idle
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    u_host.rd(ADDR_SCR_LANES, v);
    chk("rst2lanes", v, RST_SCR_LANES);
    chk("rst2count", 8'(lanesActual_r), 8'h01);
    u_host.rd(ADDR_CS_RES, v);
    chk("rst2res", v, 8'h0A);
    chk("rst2frames", 8'(cfg_r.framesPerMf), 8'h1F);
    chk("rst2cont", 8'(cfg_r.containerBits), 8'h0F);
    end_of_test;
  end
endmodule // serial_link_param_regs_tb
`default_nettype wire
